// ### logic/csb_pkg.sv
// Contract
// [RULE1] setup always carries forward and backward peak_cell_rate
// [RULE2] no best-effort or management-options field sent
// [RULE3] bearer class class_x_bearer, traffic type constant rate
// [RULE4] timing field says end-to-end timing needed
// [RULE5] clipping and connection configuration both code zero
// [RULE6] both QoS class fields select class one
// [RULE7] forum-network coding standard is binary eleven
// [RULE8] plain network: coding zero, classes unspecified zero
// [RULE9] peer refusing adaptation parameters releases, cause 93
// [RULE10] adaptation type one, subtype two, every variant
// [RULE11] channelised rate: single-channel code or multi-channel code
// [RULE12] multiplier carries N, omitted when N is one
// [RULE13] channelised service always sends structure block size
// [RULE14] partial fill sends K, else field omitted
// [RULE15] DS1 unstructured rate is the 1544 code
// [RULE16] E1 unstructured rate is the 2048 code
// [RULE17] J2 unstructured rate is the 6312 code
// [RULE18] clock recovery: zero sync, one timestamp, two adaptive
// [RULE19] channel is point-to-point between addressed endpoints
// [RULE20] adaptation and low_layer_info_element always included
// [RULE21] E1 unstructured requests 5447 cells per second
// [RULE22] received differing field raises mismatch, names element
`default_nettype none
package csb_pkg;
    // ************************************************************
    // register map
    // ************************************************************
    localparam logic [7:0] REG_CTRL = 8'h00;
    localparam logic [7:0] REG_NCHAN = 8'h04;
    localparam logic [7:0] REG_BLK = 8'h08;
    localparam logic [7:0] REG_KFILL = 8'h0C;
    localparam logic [7:0] REG_PCR = 8'h10;
    localparam logic [7:0] REG_STATUS = 8'h14;
    localparam int CTRL_SVC_LSB = 0;
    localparam int CTRL_CLKREC_LSB = 4;
    localparam int CTRL_ITU_BIT = 8;
    localparam int CTRL_PFILL_BIT = 9;
    localparam int CTRL_START_BIT = 16;
    localparam int ST_BUSY_BIT = 0;
    localparam int ST_DONE_BIT = 1;
    localparam int ST_MISM_BIT = 2;
    localparam int ST_ELEM_LSB = 4;
    localparam logic [7:0] RST_NCHAN = 8'h01;
    localparam logic [15:0] RST_BLK = 16'h0001;
    localparam logic [7:0] RST_KFILL = 8'h2F;
    localparam logic [23:0] RST_PCR = 24'h00_1547;
    // ************************************************************
    // field codes
    // ************************************************************
    localparam logic [23:0] PCR_E1 = 24'h00_1547;
    localparam logic [4:0] BCLASS_X = 5'h10;
    localparam logic [2:0] TRAFFIC_CBR = 3'h1;
    localparam logic [1:0] TIMING_E2E = 2'h1;
    localparam logic [1:0] CLIP_NONE = 2'h0;
    localparam logic [1:0] UPCC_P2P = 2'h0;
    localparam logic [1:0] QOS_STD_FORUM = 2'h3;
    localparam logic [1:0] QOS_STD_PLAIN = 2'h0;
    localparam logic [7:0] QOS_CLASS1 = 8'h01;
    localparam logic [7:0] QOS_CLASS0 = 8'h00;
    localparam logic [7:0] AAL_TYPE1 = 8'h01;
    localparam logic [7:0] AAL_SUB_CIRC = 8'h02;
    localparam logic [7:0] RATE_64 = 8'h01;
    localparam logic [7:0] RATE_NX64 = 8'h40;
    localparam logic [7:0] RATE_DS1 = 8'h04;
    localparam logic [7:0] RATE_E1 = 8'h10;
    localparam logic [7:0] RATE_J2 = 8'h05;
    localparam logic [3:0] ELEM_TD = 4'h1;
    localparam logic [3:0] ELEM_BBC = 4'h2;
    localparam logic [3:0] ELEM_QOS = 4'h3;
    localparam logic [3:0] ELEM_AAL = 4'h4;
    localparam logic [3:0] ELEM_LLI = 4'h5;

    typedef enum logic [1:0] {SVC_NX64, SVC_DS1, SVC_E1, SVC_J2} csb_svc_t;
    typedef enum logic [4:0] {
        F_TD_FWD, F_TD_BWD, F_TD_BEST, F_TD_TMOPT,
        F_BBC_CLASS, F_BBC_TRAFFIC, F_BBC_TIMING, F_BBC_CLIP, F_BBC_UPCC,
        F_QOS_CODING, F_QOS_FWD, F_QOS_BWD,
        F_AAL_TYPE, F_AAL_SUB, F_AAL_RATE, F_AAL_MULT, F_AAL_BLK,
        F_AAL_PFILL, F_AAL_CLKREC, F_LLI, F_END
    } csb_field_t;
    typedef struct packed {
        csb_svc_t svc;
        logic [1:0] clkrec;
        logic itu;
        logic pfill;
        logic [7:0] nchan;
        logic [15:0] blk;
        logic [7:0] kfill;
        logic [23:0] peak_cell_rate;
    } csb_cfg_t;

    function automatic logic field_present(csb_field_t f, csb_cfg_t c);
        logic chan;
        chan = (c.svc == SVC_NX64);
        unique case (f)
            F_TD_BEST, F_TD_TMOPT, F_END: return 1'b0; // [RULE2]
            F_AAL_MULT: return chan && (c.nchan > 8'h01); // [RULE12]
            F_AAL_BLK: return chan; // [RULE13]
            F_AAL_PFILL: return c.pfill; // [RULE14]
            F_AAL_CLKREC: return !chan; // [RULE18]
            default: return (f < F_END); // [RULE1] [RULE20]
        endcase
    endfunction

    function automatic logic [23:0] field_value(csb_field_t f, csb_cfg_t c);
        logic [7:0] q;
        q = c.itu ? QOS_CLASS0 : QOS_CLASS1; // [RULE6] [RULE8]
        unique case (f)
            F_TD_FWD, F_TD_BWD: return (c.svc == SVC_E1) ? PCR_E1 : c.peak_cell_rate; // [RULE21]
            F_BBC_CLASS: return 24'(BCLASS_X); // [RULE3]
            F_BBC_TRAFFIC: return 24'(TRAFFIC_CBR); // [RULE3]
            F_BBC_TIMING: return 24'(TIMING_E2E); // [RULE4]
            F_BBC_CLIP: return 24'(CLIP_NONE); // [RULE5]
            F_BBC_UPCC: return 24'(UPCC_P2P); // [RULE5] [RULE19]
            F_QOS_CODING: return 24'(c.itu ? QOS_STD_PLAIN : QOS_STD_FORUM); // [RULE7] [RULE8]
            F_QOS_FWD, F_QOS_BWD: return 24'(q);
            F_AAL_TYPE: return 24'(AAL_TYPE1); // [RULE10]
            F_AAL_SUB: return 24'(AAL_SUB_CIRC); // [RULE10]
            F_AAL_RATE: begin
                unique case (c.svc)
                    SVC_NX64: return 24'((c.nchan > 8'h01) ? RATE_NX64 : RATE_64); // [RULE11]
                    SVC_DS1: return 24'(RATE_DS1); // [RULE15]
                    SVC_E1: return 24'(RATE_E1); // [RULE16]
                    SVC_J2: return 24'(RATE_J2); // [RULE17]
                endcase
            end
            F_AAL_MULT: return 24'(c.nchan); // [RULE12]
            F_AAL_BLK: return 24'(c.blk); // [RULE13]
            F_AAL_PFILL: return 24'(c.kfill); // [RULE14]
            F_AAL_CLKREC: return 24'(c.clkrec); // [RULE18]
            default: return 24'h00_0000;
        endcase
    endfunction

    function automatic logic [3:0] elem_of(csb_field_t f);
        if (f <= F_TD_TMOPT) return ELEM_TD;
        if (f <= F_BBC_UPCC) return ELEM_BBC;
        if (f <= F_QOS_BWD) return ELEM_QOS;
        if (f <= F_AAL_CLKREC) return ELEM_AAL;
        if (f == F_LLI) return ELEM_LLI;
        return 4'h0;
    endfunction

    function automatic csb_field_t next_field(csb_field_t f, csb_cfg_t c);
        csb_field_t r;
        r = F_END;
        for (int i = int'(F_END) - 1; i > int'(f); i--) begin
            if (field_present(csb_field_t'(i[4:0]), c)) begin
                r = csb_field_t'(i[4:0]);
            end
        end
        return r;
    endfunction
endpackage
`default_nettype wire

// ### logic/csb_chk_if.sv
`timescale 1ns/100ps
`default_nettype none
interface csb_chk_if;
    import csb_pkg::*;
    logic clr;
    csb_cfg_t cfg;
    logic rx_valid;
    csb_field_t rx_field;
    logic [23:0] rx_value;
    logic mism;
    logic [3:0] elem;
    modport top (output clr, cfg, rx_valid, rx_field, rx_value, input mism, elem);
    modport chk (input clr, cfg, rx_valid, rx_field, rx_value, output mism, elem);
endinterface
`default_nettype wire

// ### logic/csb_checker.sv
`timescale 1ns/100ps
`default_nettype none
module csb_checker
    import csb_pkg::*;
(
    input wire logic mclk_in,
    input wire logic rst_in,
    csb_chk_if.chk chk
);
    typedef struct packed {
        logic mism;
        logic [3:0] elem;
    } csb_chk_state_t;

    csb_chk_state_t cur_ff, nxt_st;
    logic bad;

    // ************************************************************
    // received field compare
    // ************************************************************
    assign bad = chk.rx_valid && (!field_present(chk.rx_field, chk.cfg) ||
                 chk.rx_value != field_value(chk.rx_field, chk.cfg));

    always_comb begin
        nxt_st = cur_ff;
        if (chk.clr) begin
            nxt_st.mism = 1'b0;
        end
        if (bad && !(cur_ff.mism && !chk.clr)) begin
            nxt_st.mism = 1'b1; // [RULE22]
            nxt_st.elem = elem_of(chk.rx_field);
        end
    end

    always_ff @(posedge mclk_in or posedge rst_in) begin
        if (rst_in) begin
            cur_ff <= '0;
        end else begin
            cur_ff <= nxt_st;
        end
    end

    assign chk.mism = cur_ff.mism;
    assign chk.elem = cur_ff.elem;

    mism_set_a: assert property (@(posedge mclk_in) disable iff (rst_in) // [RULE22]
        bad |=> chk.mism ##0 (($past(chk.mism) && !$past(chk.clr)) ||
        chk.elem == elem_of($past(chk.rx_field))))
        else $error("mismatch not flagged");
    p2p_bad_a: assert property (@(posedge mclk_in) disable iff (rst_in) // [RULE19]
        chk.rx_valid && chk.rx_field == F_BBC_UPCC && chk.rx_value != 24'h00_0000
        |=> chk.mism)
        else $error("non point-to-point accepted");
endmodule
`default_nettype wire

// ### logic/csb_ie_builder.sv
// Local design decisions: the APB slave port and the register addresses.
`timescale 1ns/100ps
`default_nettype none
module csb_ie_builder
    import csb_pkg::*;
(
    input wire logic mclk_in,
    input wire logic rst_in,
    input wire logic psel_in,
    input wire logic penable_in,
    input wire logic pwrite_in,
    input wire logic [7:0] paddr_in,
    input wire logic [31:0] pwdata_in,
    output logic pready_out,
    output logic [31:0] prdata_out,
    output logic pslverr_out,
    output logic tx_valid_out,
    input wire logic tx_ready_in,
    output logic [3:0] tx_elem_out,
    output logic [4:0] tx_field_out,
    output logic [23:0] tx_value_out,
    output logic tx_last_out,
    output logic busy_out,
    input wire logic rx_valid_in,
    input wire logic [4:0] rx_field_in,
    input wire logic [23:0] rx_value_in,
    output logic mismatch_out,
    output logic [3:0] mismatch_elem_out
);
    typedef enum logic {ST_IDLE, ST_EMIT} csb_state_t;
    typedef struct packed {
        csb_cfg_t cfg;
        csb_cfg_t run;
        csb_state_t fsm;
        csb_field_t fid;
        logic [3:0] elem;
        logic [23:0] value;
        logic done;
        logic clr;
        logic [31:0] prdata;
    } csb_top_state_t;

    csb_top_state_t cur_ff, nxt_st;
    csb_chk_if chk_bus();
    logic acc_wr;
    logic setup_rd;
    logic hit;
    logic start;
    csb_field_t nxt_fid;

    // ************************************************************
    // apb decode
    // ************************************************************
    assign acc_wr = psel_in && penable_in && pwrite_in;
    assign setup_rd = psel_in && !penable_in && !pwrite_in;
    assign hit = (paddr_in == REG_CTRL) || (paddr_in == REG_NCHAN) ||
                 (paddr_in == REG_BLK) || (paddr_in == REG_KFILL) ||
                 (paddr_in == REG_PCR) || (paddr_in == REG_STATUS);
    assign pready_out = 1'b1;
    assign pslverr_out = psel_in && penable_in && !hit;
    assign prdata_out = cur_ff.prdata;

    assign start = acc_wr && (paddr_in == REG_CTRL) && pwdata_in[CTRL_START_BIT] &&
                   (cur_ff.fsm == ST_IDLE);
    assign nxt_fid = next_field(cur_ff.fid, cur_ff.run);

    // ************************************************************
    // next state
    // ************************************************************
    always_comb begin
        nxt_st = cur_ff;
        nxt_st.clr = 1'b0;
        if (acc_wr) begin
            unique case (paddr_in)
                REG_CTRL: begin
                    nxt_st.cfg.svc = csb_svc_t'(pwdata_in[CTRL_SVC_LSB +: 2]);
                    nxt_st.cfg.clkrec = (pwdata_in[CTRL_CLKREC_LSB +: 2] == 2'h3) ? 2'h2 :
                                        pwdata_in[CTRL_CLKREC_LSB +: 2]; // [RULE18]
                    nxt_st.cfg.itu = pwdata_in[CTRL_ITU_BIT];
                    nxt_st.cfg.pfill = pwdata_in[CTRL_PFILL_BIT];
                end
                REG_NCHAN: nxt_st.cfg.nchan = pwdata_in[7:0];
                REG_BLK: nxt_st.cfg.blk = pwdata_in[15:0];
                REG_KFILL: nxt_st.cfg.kfill = pwdata_in[7:0];
                REG_PCR: nxt_st.cfg.peak_cell_rate = pwdata_in[23:0];
                REG_STATUS: nxt_st.clr = pwdata_in[ST_MISM_BIT];
                default: ;
            endcase
        end
        if (setup_rd) begin
            nxt_st.prdata = 32'h0000_0000;
            unique case (paddr_in)
                REG_CTRL: begin
                    nxt_st.prdata[CTRL_SVC_LSB +: 2] = cur_ff.cfg.svc;
                    nxt_st.prdata[CTRL_CLKREC_LSB +: 2] = cur_ff.cfg.clkrec;
                    nxt_st.prdata[CTRL_ITU_BIT] = cur_ff.cfg.itu;
                    nxt_st.prdata[CTRL_PFILL_BIT] = cur_ff.cfg.pfill;
                end
                REG_NCHAN: nxt_st.prdata[7:0] = cur_ff.cfg.nchan;
                REG_BLK: nxt_st.prdata[15:0] = cur_ff.cfg.blk;
                REG_KFILL: nxt_st.prdata[7:0] = cur_ff.cfg.kfill;
                REG_PCR: nxt_st.prdata[23:0] = cur_ff.cfg.peak_cell_rate;
                REG_STATUS: begin
                    nxt_st.prdata[ST_BUSY_BIT] = (cur_ff.fsm == ST_EMIT);
                    nxt_st.prdata[ST_DONE_BIT] = cur_ff.done;
                    nxt_st.prdata[ST_MISM_BIT] = chk_bus.mism;
                    nxt_st.prdata[ST_ELEM_LSB +: 4] = chk_bus.elem;
                end
                default: ;
            endcase
        end
        unique case (cur_ff.fsm)
            ST_IDLE: begin
                if (start) begin
                    // snapshot so later writes cannot tear a message
                    nxt_st.run = nxt_st.cfg;
                    nxt_st.fid = F_TD_FWD; // [RULE1]
                    nxt_st.elem = ELEM_TD;
                    nxt_st.value = field_value(F_TD_FWD, nxt_st.cfg);
                    nxt_st.done = 1'b0;
                    nxt_st.fsm = ST_EMIT;
                end
            end
            ST_EMIT: begin
                if (tx_ready_in) begin
                    if (nxt_fid == F_END) begin
                        nxt_st.fsm = ST_IDLE;
                        nxt_st.done = 1'b1;
                    end else begin
                        nxt_st.fid = nxt_fid; // [RULE2] [RULE20]
                        nxt_st.elem = elem_of(nxt_fid);
                        nxt_st.value = field_value(nxt_fid, cur_ff.run);
                    end
                end
            end
        endcase
    end

    always_ff @(posedge mclk_in or posedge rst_in) begin
        if (rst_in) begin
            cur_ff <= '0;
            cur_ff.cfg.svc <= SVC_E1;
            cur_ff.cfg.nchan <= RST_NCHAN;
            cur_ff.cfg.blk <= RST_BLK;
            cur_ff.cfg.kfill <= RST_KFILL;
            cur_ff.cfg.peak_cell_rate <= RST_PCR;
            cur_ff.fsm <= ST_IDLE;
            cur_ff.fid <= F_TD_FWD;
        end else begin
            cur_ff <= nxt_st;
        end
    end

    // ************************************************************
    // outputs and checker
    // ************************************************************
    assign tx_valid_out = (cur_ff.fsm == ST_EMIT);
    assign tx_elem_out = cur_ff.elem;
    assign tx_field_out = cur_ff.fid;
    assign tx_value_out = cur_ff.value;
    assign tx_last_out = tx_valid_out && (nxt_fid == F_END);
    assign busy_out = tx_valid_out;

    assign chk_bus.clr = cur_ff.clr;
    assign chk_bus.cfg = cur_ff.cfg;
    assign chk_bus.rx_valid = rx_valid_in;
    assign chk_bus.rx_field = csb_field_t'(rx_field_in);
    assign chk_bus.rx_value = rx_value_in;
    assign mismatch_out = chk_bus.mism;
    assign mismatch_elem_out = chk_bus.elem;

    csb_checker u_chk (
        .mclk_in(mclk_in),
        .rst_in(rst_in),
        .chk(chk_bus.chk)
    );

    // ************************************************************
    // checks
    // ************************************************************
    default clocking @(posedge mclk_in); endclocking
    default disable iff (rst_in);

    td_pair_a: assert property ( // [RULE1]
        tx_valid_out && tx_ready_in && tx_field_out == F_TD_FWD
        |=> tx_valid_out && tx_field_out == F_TD_BWD)
        else $error("backward rate not after forward");
    td_first_a: assert property ( // [RULE1]
        start |=> tx_valid_out && tx_field_out == F_TD_FWD)
        else $error("message does not open with forward rate");
    td_omit_a: assert property ( // [RULE2]
        tx_valid_out |-> tx_field_out != F_TD_BEST && tx_field_out != F_TD_TMOPT)
        else $error("forbidden traffic field sent");
    bbc_code_a: assert property ( // [RULE3]
        tx_valid_out && tx_field_out == F_BBC_CLASS |-> tx_value_out == 24'h00_0010
        && tx_elem_out == ELEM_BBC)
        else $error("bearer class code wrong");
    bbc_seq_a: assert property ( // [RULE4]
        tx_valid_out && tx_ready_in && tx_field_out == F_BBC_TRAFFIC
        |=> tx_field_out == F_BBC_TIMING && tx_value_out == 24'h00_0001)
        else $error("timing field wrong");
    qos_class_a: assert property ( // [RULE6]
        tx_valid_out && tx_field_out == F_QOS_FWD
        |-> tx_value_out == (cur_ff.run.itu ? 24'h00_0000 : 24'h00_0001))
        else $error("qos class wrong");
    qos_std_a: assert property ( // [RULE7]
        tx_valid_out && tx_field_out == F_QOS_CODING && !cur_ff.run.itu
        |-> tx_value_out == 24'h00_0003)
        else $error("coding standard wrong");
    mult_omit_a: assert property ( // [RULE12]
        tx_valid_out && tx_field_out == F_AAL_MULT
        |-> cur_ff.run.svc == SVC_NX64 && cur_ff.run.nchan > 8'h01)
        else $error("multiplier sent for single channel");
    e1_pcr_a: assert property ( // [RULE21]
        tx_valid_out && tx_elem_out == ELEM_TD && cur_ff.run.svc == SVC_E1
        |-> tx_value_out == 24'h00_1547)
        else $error("e1 cell rate wrong");
    ds1_rate_a: assert property ( // [RULE15]
        tx_valid_out && tx_field_out == F_AAL_RATE && cur_ff.run.svc == SVC_DS1
        |-> tx_value_out == 24'h00_0004)
        else $error("ds1 rate code wrong");
    tx_hold_a: assert property (
        tx_valid_out && !tx_ready_in |=> tx_valid_out && $stable(tx_value_out)
        && $stable(tx_field_out))
        else $error("field dropped under back-pressure");
    lli_last_a: assert property ( // [RULE20]
        tx_last_out |-> tx_field_out == F_LLI ##1 (!tx_valid_out || !$past(tx_ready_in)))
        else $error("message does not end with low layer element");
endmodule
`default_nettype wire

// ### verif/csb_peer_model.sv
`timescale 1ns/100ps
`default_nettype none
// ************************************************************
// far-side consumer of the field stream, one point-to-point peer
// ************************************************************
module csb_peer_model
    import csb_pkg::*;
(
    input wire logic mclk_in,
    input wire logic rst_in,
    input wire logic slow_in,
    input wire logic tx_valid_in,
    input wire logic [4:0] tx_field_in,
    input wire logic [23:0] tx_value_in,
    output logic tx_ready_out,
    output logic [7:0] cause_out
);
    always @(posedge mclk_in or posedge rst_in) begin
        if (rst_in) begin
            tx_ready_out <= 1'b0;
            cause_out <= 8'h00;
        end else begin
            tx_ready_out <= slow_in ? 1'($urandom % 2) : 1'b1;
            if (tx_valid_in && tx_ready_out && tx_field_in == 5'(F_AAL_TYPE)
                && tx_value_in != 24'h00_0001) begin
                cause_out <= 8'h5D;
            end
        end
    end
endmodule
`default_nettype wire

// ### verif/circuit_setup_ie_builder_test.sv
`timescale 1ns/100ps
`default_nettype none
module circuit_setup_ie_builder_test
    import csb_pkg::*;
    ;
    logic mclk_in = 1'b0, rst_in = 1'b1, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
    logic [7:0] paddr = 8'h00;
    logic [31:0] pwdata = 32'h0000_0000, prdata, rd;
    logic rx_valid = 1'b0, slow = 1'b0, pready, pslverr, er, tx_valid, tx_ready, tx_last, busy;
    logic [4:0] rx_field = 5'h00, tx_field;
    logic [23:0] rx_value = 24'h00_0000, tx_value;
    logic [3:0] tx_elem, mism_elem;
    logic mism;
    logic [7:0] peer_cause;
    logic [33:0] exp_q[$];
    int mismatches = 0, samples_checked = 0;
    always #12.5 mclk_in = ~mclk_in;
    csb_ie_builder dut (.mclk_in(mclk_in), .rst_in(rst_in), .psel_in(psel),
        .penable_in(penable), .pwrite_in(pwrite), .paddr_in(paddr), .pwdata_in(pwdata),
        .pready_out(pready), .prdata_out(prdata), .pslverr_out(pslverr),
        .tx_valid_out(tx_valid), .tx_ready_in(tx_ready), .tx_elem_out(tx_elem),
        .tx_field_out(tx_field), .tx_value_out(tx_value), .tx_last_out(tx_last),
        .busy_out(busy), .rx_valid_in(rx_valid), .rx_field_in(rx_field),
        .rx_value_in(rx_value), .mismatch_out(mism), .mismatch_elem_out(mism_elem));
    csb_peer_model peer (.mclk_in(mclk_in), .rst_in(rst_in), .slow_in(slow),
        .tx_valid_in(tx_valid), .tx_field_in(tx_field), .tx_value_in(tx_value),
        .tx_ready_out(tx_ready), .cause_out(peer_cause));
    // ************************************************************
    // shared tasks
    // ************************************************************
    task chk(input string n, input logic [33:0] e, input logic [33:0] s);
        samples_checked++;
        if (s !== e) begin
            mismatches++;
            $display("ERROR %s expected %h seen %h", n, e, s);
        end
    endtask
    task results;
        if (mismatches == 0 && samples_checked > 0) $display("Test passed");
        else $display("Test failed");
        $finish;
    endtask
    task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
        @(posedge mclk_in);
        psel <= 1'b1; penable <= 1'b0; pwrite <= w; paddr <= a; pwdata <= d;
        @(posedge mclk_in);
        penable <= 1'b1;
        do begin
            @(posedge mclk_in);
        end while (pready !== 1'b1);
        rd = prdata;
        er = pslverr;
        psel <= 1'b0; penable <= 1'b0;
    endtask
    task add(input csb_field_t f, input logic [23:0] v);
        logic [3:0] e;
        e = (f <= F_TD_TMOPT) ? 4'h1 : (f <= F_BBC_UPCC) ? 4'h2 : (f <= F_QOS_BWD) ? 4'h3
            : (f <= F_AAL_CLKREC) ? 4'h4 : 4'h5;
        exp_q.push_back({f == F_LLI, e, 5'(f), v});
    endtask
    task build(input csb_svc_t s, input logic [1:0] c, input logic q, input logic p,
               input logic [7:0] n, input logic [15:0] b, input logic [7:0] k,
               input logic [23:0] r, input logic sl);
        logic [31:0] cw;
        logic [23:0] pe;
        logic [7:0] rate;
        logic x;
        int t;
        x = (s == SVC_NX64);
        pe = (s == SVC_E1) ? 24'h00_1547 : r;
        rate = x ? (n > 8'h01 ? 8'h40 : 8'h01) : s == SVC_DS1 ? 8'h04
            : s == SVC_E1 ? 8'h10 : 8'h05;
        slow <= sl;
        apb(1'b1, REG_NCHAN, 32'(n));
        apb(1'b1, REG_BLK, 32'(b));
        apb(1'b1, REG_KFILL, 32'(k));
        apb(1'b1, REG_PCR, 32'(r));
        add(F_TD_FWD, pe);
        add(F_TD_BWD, pe);
        add(F_BBC_CLASS, 24'h00_0010);
        add(F_BBC_TRAFFIC, 24'h00_0001);
        add(F_BBC_TIMING, 24'h00_0001);
        add(F_BBC_CLIP, 24'h00_0000);
        add(F_BBC_UPCC, 24'h00_0000);
        add(F_QOS_CODING, q ? 24'h00_0000 : 24'h00_0003);
        add(F_QOS_FWD, q ? 24'h00_0000 : 24'h00_0001);
        add(F_QOS_BWD, q ? 24'h00_0000 : 24'h00_0001);
        add(F_AAL_TYPE, 24'h00_0001);
        add(F_AAL_SUB, 24'h00_0002);
        add(F_AAL_RATE, 24'(rate));
        if (x && n > 8'h01) add(F_AAL_MULT, 24'(n));
        if (x) add(F_AAL_BLK, 24'(b));
        if (p) add(F_AAL_PFILL, 24'(k));
        if (!x) add(F_AAL_CLKREC, 24'(c));
        add(F_LLI, 24'h00_0000);
        cw = 32'(s) | (32'(c) << CTRL_CLKREC_LSB) | (32'(q) << CTRL_ITU_BIT)
            | (32'(p) << CTRL_PFILL_BIT);
        apb(1'b1, REG_CTRL, cw | 32'h0001_0000);
        if (sl) apb(1'b1, REG_CTRL, cw | 32'h0001_0000);
        apb(1'b0, REG_CTRL, 32'h0000_0000);
        chk("ctrl", 34'(cw), 34'(rd));
        t = 0;
        do begin
            apb(1'b0, REG_STATUS, 32'h0000_0000);
            t++;
        end while (rd[ST_BUSY_BIT] !== 1'b0 && t < 100);
        chk("status", 34'h2, 34'(rd[3:0]));
        chk("busy idle", 34'h0, 34'(busy));
        chk("beats left", 34'h0, 34'(exp_q.size()));
    endtask
    task rx(input csb_field_t f, input logic [23:0] v, input logic [4:0] e);
        @(posedge mclk_in);
        rx_valid <= 1'b1; rx_field <= 5'(f); rx_value <= v;
        @(posedge mclk_in);
        rx_valid <= 1'b0;
        @(posedge mclk_in);
        chk("mismatch", 34'(e), 34'({mism, mism_elem}));
    endtask
    // ************************************************************
    // stream monitor and watchdog
    // ************************************************************
    always @(posedge mclk_in) begin
        if (tx_valid === 1'b1 && tx_ready === 1'b1) begin
            chk("busy", 34'h1, 34'(busy));
            if (exp_q.size() == 0) chk("extra beat", 34'h0, 34'h1);
            else chk("tx beat", exp_q.pop_front(), {tx_last, tx_elem, tx_field, tx_value});
        end
    end
    initial begin
        #(25 * 50000);
        mismatches++;
        results;
    end
    // ************************************************************
    // main sequence
    // ************************************************************
    initial begin
        logic [7:0] ra[6];
        logic [31:0] rv[6];
        ra = '{REG_CTRL, REG_NCHAN, REG_BLK, REG_KFILL, REG_PCR, REG_STATUS};
        rv = '{32'h0000_0002, 32'h0000_0001, 32'h0000_0001, 32'h0000_002F,
            32'h0000_1547, 32'h0000_0000};
        void'($urandom(32'hc1ed));
        repeat (20) @(posedge mclk_in);
        rst_in <= 1'b0;
        for (int i = 0; i < 6; i++) begin
            apb(1'b0, ra[i], 32'h0000_0000);
            chk("reset value", 34'(rv[i]), 34'(rd));
        end
        apb(1'b0, 8'h20, 32'h0000_0000);
        chk("unmapped", 34'h1_0000_0000, 34'({er, rd}));
        for (int i = 0; i < 12; i++) begin
            build(csb_svc_t'(i[1:0]), 2'(i % 3), i[2], i[0],
                (i == 0) ? 8'h01 : 8'(2 + $urandom % 30), 16'(1 + $urandom % 512),
                8'(1 + $urandom % 47), 24'($urandom), i[1] ^ i[2]);
        end
        apb(1'b1, REG_CTRL, 32'h0000_0001);
        rx(F_BBC_CLASS, 24'h00_0010, 5'h00);
        rx(F_AAL_MULT, 24'h00_0002, 5'h14);
        rx(F_QOS_CODING, 24'h00_0000, 5'h14);
        apb(1'b1, REG_STATUS, 32'h0000_0004);
        rx(F_AAL_RATE, 24'h00_0004, 5'h04);
        rx(F_QOS_CODING, 24'h00_0000, 5'h13);
        apb(1'b1, REG_STATUS, 32'h0000_0004);
        rx(F_BBC_UPCC, 24'h00_0001, 5'h12);
        chk("release cause", 34'h0, 34'(peer_cause));
        results;
    end
endmodule
`default_nettype wire
